// >>> nhbi_defines.vh
// constants for the host bus interface block
// assumes inclusion by bare name from the design file
`ifndef NHBI_DEFINES_VH
`define NHBI_DEFINES_VH
`define NHBI_CLK_NS 10
`define NHBI_SYNC_LEN 2
`define NHBI_DMA_STATES 4
`define NHBI_RDY_PERIOD_NS 40
`define NHBI_DMA_CYCLE_CLOCK_DIV 4
`define NHBI_SEL_RST 4'h0
`define NHBI_DATA_RST 8'h00
`define NHBI_ADDR_RST 16'h0000
// synchroniser idle levels: strobes and chip select high, register select, grant and ready low
`define NHBI_SYNC_RST 26'h21C0000
`endif

// >>> nhbi_host_bus.v
// host bus interface: slave register port and bus master memory cycles
// assumes every pin input is asynchronous; tristate resolved outside
`timescale 1ns/10ps
`default_nettype none
`include "nhbi_defines.vh"
// Notes on behaviour
// - slave register data on low byte
// - upper byte floats during slave transfers
// - master drives address on all lines in t1
// - word mode: sixteen data lines t2 to t4
// - byte mode: low data, high address byte
// - master read/write strobes give direction
// - select latched on address strobe fall
// - select latch transparent while strobe high
// - master drives address strobe for address
// - chip select enters slave register access
// - write strobe low in t2, t3, wait
// - write strobe rises with valid data
// - write strobe floats until bus grant
// - four-clock cycle, one wait on ready
// - acknowledge low once access synchronized
// - write on strobe rise, read on fall
module nhbi_host_bus #(
    parameter DIV = `NHBI_DMA_CYCLE_CLOCK_DIV
) (
    // clock and reset
    input wire core_clk,
    input wire srst,
    // slave side pins
    input wire chip_sel_n,
    input wire [3:0] reg_select_lines,
    input wire slave_read_strobe_n,
    input wire slave_write_strobe_n,
    output reg ack_n,
    // address strobe pin, three signals
    input wire addr_strobe_zero_in,
    output reg addr_strobe_zero_out,
    output reg addr_strobe_zero_oe,
    // multiplexed bus pin, three signals
    input wire [15:0] muxed_addr_data_lines_in,
    output reg [15:0] muxed_addr_data_lines_out,
    output reg [15:0] muxed_addr_data_lines_oe,
    // master side pins
    input wire bus_grant,
    input wire ready,
    output reg master_read_strobe_n,
    output reg master_read_strobe_oe,
    output reg master_write_strobe_n,
    output reg master_write_strobe_oe,
    // internal register file side
    output reg [3:0] reg_sel,
    output reg reg_wr,
    output reg [7:0] reg_wdata,
    output reg reg_rd,
    input wire [7:0] reg_rdata,
    // internal dma side
    input wire dma_active,
    input wire dma_req,
    input wire dma_write,
    input wire dma_word_mode,
    input wire [15:0] dma_addr,
    input wire [15:0] dma_wdata,
    output reg [15:0] dma_rdata,
    output reg dma_done
);
// =====================================================================
// input synchronisers
localparam NS = 26;
reg [NS-1:0] s1_r;
reg [NS-1:0] s2_r;
wire [NS-1:0] raw = {chip_sel_n, reg_select_lines, slave_read_strobe_n,
    slave_write_strobe_n, addr_strobe_zero_in, bus_grant, ready,
    muxed_addr_data_lines_in};
// reset to idle pin levels: no false grant or strobe edge after reset
always @(posedge core_clk) begin
    if (srst) begin
        s1_r <= `NHBI_SYNC_RST;
        s2_r <= `NHBI_SYNC_RST;
    end else begin
        s1_r <= raw;
        s2_r <= s1_r;
    end
end
wire cs_n = s2_r[25];
wire [3:0] ra = s2_r[24:21];
wire srd_n = s2_r[20];
wire swr_n = s2_r[19];
wire ads_in = s2_r[18];
wire grant = s2_r[17];
wire rdy = s2_r[16];
wire [15:0] ad_in = s2_r[15:0];
reg srd_d_r;
reg swr_d_r;
reg ads_d_r;
// =====================================================================
// slave register access
wire slave_ok = !dma_active && !cs_n;
reg [3:0] sel_latch_r;
reg [7:0] rd_hold_r;
reg rd_drive_r;
always @(posedge core_clk) begin
    if (srst) begin
        srd_d_r <= 1'b1;
        swr_d_r <= 1'b1;
        ads_d_r <= 1'b1;
        sel_latch_r <= `NHBI_SEL_RST;
        reg_sel <= `NHBI_SEL_RST;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_wdata <= `NHBI_DATA_RST;
        rd_hold_r <= `NHBI_DATA_RST;
        rd_drive_r <= 1'b0;
        ack_n <= 1'b1;
    end else begin
        srd_d_r <= srd_n;
        swr_d_r <= swr_n;
        ads_d_r <= ads_in;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        if (slave_ok && ads_in)
            sel_latch_r <= ra;
        else if (slave_ok && ads_d_r && !ads_in)
            sel_latch_r <= ra;
        reg_sel <= (slave_ok && ads_in) ? ra : sel_latch_r;
        // direction taken from whichever strobe the host asserts
        if (slave_ok && srd_d_r && !srd_n) begin
            reg_rd <= 1'b1;
            rd_hold_r <= reg_rdata;
            rd_drive_r <= 1'b1;
            ack_n <= 1'b0;
        end else if (slave_ok && swr_d_r && !swr_n) begin
            ack_n <= 1'b0;
        end else if (slave_ok && !swr_d_r && swr_n) begin
            reg_wr <= 1'b1;
            reg_wdata <= ad_in[7:0];
        end
        // chip select held by host through data
        if (cs_n || (srd_n && swr_n)) begin
            ack_n <= 1'b1;
            rd_drive_r <= 1'b0;
        end
    end
end
// =====================================================================
// bus master cycles: t1..t4 plus one wait, on divided clock
localparam ST_IDLE = 6'b000001;
localparam ST_T1 = 6'b000010;
localparam ST_T2 = 6'b000100;
localparam ST_T3 = 6'b001000;
localparam ST_TW = 6'b010000;
localparam ST_T4 = 6'b100000;
reg [5:0] st_r;
reg [5:0] st_nxt;
reg [7:0] div_r;
wire tick = (div_r == DIV[7:0] - 8'h01);
reg wr_r;
reg word_r;
reg [15:0] addr_r;
reg [15:0] wdata_r;
always @* begin
    case (st_r)
        ST_IDLE: st_nxt = (grant && dma_req) ? ST_T1 : ST_IDLE;
        ST_T1: st_nxt = ST_T2;
        ST_T2: st_nxt = ST_T3;
        ST_T3: st_nxt = rdy ? ST_TW : ST_T4;
        ST_TW: st_nxt = ST_T4;
        ST_T4: st_nxt = ST_IDLE;
        default: st_nxt = ST_IDLE;
    endcase
end
always @(posedge core_clk) begin
    if (srst) begin
        div_r <= 8'h00;
        st_r <= ST_IDLE;
        wr_r <= 1'b0;
        word_r <= 1'b0;
        addr_r <= `NHBI_ADDR_RST;
        wdata_r <= `NHBI_ADDR_RST;
        dma_rdata <= `NHBI_ADDR_RST;
        dma_done <= 1'b0;
    end else begin
        dma_done <= 1'b0;
        div_r <= tick ? 8'h00 : div_r + 8'h01;
        if (tick) begin
            st_r <= st_nxt;
            if (st_r == ST_IDLE && st_nxt == ST_T1) begin
                wr_r <= dma_write;
                word_r <= dma_word_mode;
                addr_r <= dma_addr;
                wdata_r <= dma_wdata;
            end
            if (st_r == ST_T4) begin
                dma_done <= 1'b1;
                if (!wr_r)
                    dma_rdata <= word_r ? ad_in
                        : {8'h00, ad_in[7:0]};
            end
        end
    end
end
// =====================================================================
// pin drive
wire mst = grant && (st_r != ST_IDLE);
wire dphase = (st_r == ST_T2) || (st_r == ST_T3) || (st_r == ST_TW)
    || (st_r == ST_T4);
wire strobe_on = (st_r == ST_T2) || (st_r == ST_T3) || (st_r == ST_TW);
always @* begin
    muxed_addr_data_lines_out = 16'h0000;
    muxed_addr_data_lines_oe = 16'h0000;
    addr_strobe_zero_out = 1'b1;
    addr_strobe_zero_oe = 1'b0;
    master_read_strobe_n = 1'b1;
    master_write_strobe_n = 1'b1;
    master_read_strobe_oe = grant;
    master_write_strobe_oe = grant;
    if (mst) begin
        addr_strobe_zero_oe = 1'b1;
        addr_strobe_zero_out = (st_r == ST_T1) ? 1'b1 : 1'b0;
        if (st_r == ST_T1) begin
            muxed_addr_data_lines_out = addr_r;
            muxed_addr_data_lines_oe = 16'hFFFF;
        end else if (dphase) begin
            muxed_addr_data_lines_oe[15:8] = 8'hFF;
            muxed_addr_data_lines_out[15:8] =
                word_r ? wdata_r[15:8] : addr_r[15:8];
            if (!word_r)
                muxed_addr_data_lines_oe[15:8] = 8'hFF;
            else if (!wr_r)
                muxed_addr_data_lines_oe[15:8] = 8'h00;
            if (wr_r) begin
                muxed_addr_data_lines_out[7:0] = wdata_r[7:0];
                muxed_addr_data_lines_oe[7:0] = 8'hFF;
            end
        end
        master_write_strobe_n = !(wr_r && strobe_on);
        master_read_strobe_n = !(!wr_r && strobe_on);
    end else if (rd_drive_r && slave_ok) begin
        muxed_addr_data_lines_out[7:0] = rd_hold_r;
        muxed_addr_data_lines_oe[7:0] = 8'hFF;
    end
end
endmodule // nhbi_host_bus
`default_nettype wire

// >>> nhbi_host_bus_checker.sv
// timing checks on the host bus interface block ports
// assumes binding onto nhbi_host_bus, all pins sampled on core_clk
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// slave and master port properties
module nhbi_host_bus_checker #(parameter int DIV = 4) (
    input wire logic core_clk, srst, ack_n, slave_read_strobe_n, bus_grant,
    input wire logic dma_word_mode, addr_strobe_zero_out, addr_strobe_zero_oe,
    input wire logic master_read_strobe_oe, master_read_strobe_n,
    input wire logic master_write_strobe_n, master_write_strobe_oe,
    input wire logic [15:0] dma_addr, dma_wdata, muxed_addr_data_lines_out,
    input wire logic [15:0] muxed_addr_data_lines_oe
);
    localparam int LO = 2 * DIV;
    localparam int HI = 3 * DIV;
    wire [15:0] oe = muxed_addr_data_lines_oe;
    wire [15:0] dq = muxed_addr_data_lines_out;
    wire slave_read_strobe = slave_read_strobe_n;
    wire mw = master_write_strobe_n;
    wire mwe = master_write_strobe_oe;
    wire wl = mwe & ~mw;
    wire ads = addr_strobe_zero_oe & addr_strobe_zero_out;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    property p_hi; !ack_n |-> oe[15:8] == 8'h00; endproperty
    a_hi: assert property (p_hi) else $error("upper byte driven");
    property p_rd; !ack_n && !slave_read_strobe |-> oe[7:0] == 8'hFF; endproperty
    a_rd: assert property (p_rd) else $error("read byte not driven");
    property p_flt; ack_n && !master_read_strobe_oe |-> oe == 16'h0000;
    endproperty
    a_flt: assert property (p_flt) else $error("idle bus driven");
    property p_gnt; !bus_grant [*3] |-> !mwe; endproperty
    a_gnt: assert property (p_gnt) else $error("strobe without grant");
    property p_t1; ads |-> oe == 16'hFFFF && dq == dma_addr; endproperty
    a_t1: assert property (p_t1) else $error("bad address phase");
    property p_wd;
        wl && dma_word_mode |-> oe == 16'hFFFF && dq == dma_wdata;
    endproperty
    a_wd: assert property (p_wd) else $error("bad word data");
    property p_by;
        wl && !dma_word_mode |-> oe == 16'hFFFF
            && dq == {dma_addr[15:8], dma_wdata[7:0]};
    endproperty
    a_by: assert property (p_by) else $error("bad byte mode high");
    property p_mrd;
        !master_read_strobe_n |-> master_read_strobe_oe && mw
            && oe[7:0] == 8'h00;
    endproperty
    a_mrd: assert property (p_mrd) else $error("bad read strobe");
    property p_len; $fell(mw) && mwe |-> ##[LO:HI] $rose(mw); endproperty
    a_len: assert property (p_len) else $error("bad strobe length");
    c_rd: cover property (!ack_n && !slave_read_strobe);
    c_wt: cover property ($fell(mw) ##3 $rose(mw));
    c_t1: cover property (ads);
endmodule // nhbi_host_bus_checker
bind nhbi_host_bus nhbi_host_bus_checker #(.DIV(DIV)) u_chk (.*);
`default_nettype wire

// >>> nhbi_mem_model.sv
// buffer memory and bus resolution for the host bus bench
// assumes address strobe high marks the address phase
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// memory answers reads with the inverted address
module nhbi_mem_model (
    input wire logic clk, ads, rd,
    input wire logic [8:0] hd,
    input wire logic [15:0] oe, dout,
    output logic [15:0] din
);
    logic [15:0] addr_r = 16'h0000, last_r = 16'h0000, far;
    // released lines show the inverted address on reads, else the inverse of their last level, low byte host data while hd[8] is set
    assign far = rd ? ~addr_r : hd[8] ? {~last_r[15:8], hd[7:0]} : ~last_r;
    assign din = (oe & dout) | (~oe & far);
    always @(posedge clk) begin
        last_r <= din;
        if (ads) addr_r <= din;
    end
endmodule // nhbi_mem_model
`default_nettype wire

// >>> nic_host_bus_interface_tb.sv
// self-checking bench for the host bus interface block
// assumes nhbi_host_bus, nhbi_mem_model and the bound checker
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// stimulus, monitor and verdict
module nic_host_bus_interface_tb;
    logic core_clk = 0, srst = 1, chip_sel_n = 1, bus_grant = 0, ready = 0;
    logic slave_read_strobe_n = 1, slave_write_strobe_n = 1, dma_req = 0;
    logic addr_strobe_zero_in = 1, dma_active = 0, dma_write = 0;
    logic dma_word_mode = 1, ack_n, addr_strobe_zero_out, addr_strobe_zero_oe;
    logic master_read_strobe_n, master_read_strobe_oe, reg_wr, reg_rd;
    logic master_write_strobe_n, master_write_strobe_oe, dma_done;
    logic [3:0] reg_select_lines = 4'h0, reg_sel;
    logic [7:0] reg_rdata = 8'h00, reg_wdata;
    logic [8:0] h_d = 9'h000;
    logic [15:0] dma_addr = 16'h0000, dma_wdata = 16'h0000, dma_rdata;
    logic [15:0] muxed_addr_data_lines_in, muxed_addr_data_lines_out;
    logic [15:0] muxed_addr_data_lines_oe;
    logic [19:0] exp_q[$];
    int fail_count = 0, total_checks = 0, i, n;
    wire [19:0] got = {7'h50, reg_wr, reg_sel, reg_wdata & {8{reg_wr}}};
    always #5 core_clk = ~core_clk;
    nhbi_host_bus #(.DIV(1)) DUT (.*);
    nhbi_mem_model u_mem (.clk(core_clk), .hd(h_d),
        .ads(addr_strobe_zero_oe & addr_strobe_zero_out),
        .rd(master_read_strobe_oe & ~master_read_strobe_n),
        .oe(muxed_addr_data_lines_oe), .dout(muxed_addr_data_lines_out),
        .din(muxed_addr_data_lines_in));
    task chk(input logic [19:0] g, input logic [19:0] e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task finish_test(input int extra);
        fail_count += extra;
        if (fail_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task host(input logic wr, input logic [3:0] sel, input logic [7:0] d);
        @(negedge core_clk) chip_sel_n = 0;
        reg_select_lines = sel;
        reg_rdata = 8'($urandom);
        h_d = {wr, d};
        @(negedge core_clk) addr_strobe_zero_in = 0;
        @(negedge core_clk) reg_select_lines = ~sel;
        if (!dma_active) exp_q.push_back({7'h50, wr, sel, wr ? d : 8'h00});
        if (wr) slave_write_strobe_n = 0;
        else slave_read_strobe_n = 0;
        for (n = 0; n < 8 && ack_n !== 1'b0; n++) @(negedge core_clk);
        chk(20'(ack_n), 20'(dma_active));
        if (!wr && !dma_active)
            chk(20'(muxed_addr_data_lines_out[7:0]), 20'(reg_rdata));
        @(negedge core_clk) {slave_read_strobe_n, slave_write_strobe_n} = 2'b11;
        repeat (6) @(negedge core_clk);
        {chip_sel_n, addr_strobe_zero_in, h_d[8]} = 3'b110;
    endtask
    task dma(input logic wr, input logic word, input logic wt);
        @(negedge core_clk) {dma_write, dma_word_mode, ready} = {wr, word, wt};
        {dma_addr, dma_wdata} = $urandom;
        if (!wr)
            exp_q.push_back({4'hD, word ? ~dma_addr[15:8] : 8'h00,
                ~dma_addr[7:0]});
        dma_req = 1;
        for (n = 0; n < 40 && dma_done !== 1'b1; n++) @(negedge core_clk);
        dma_req = 0;
        chk(20'(n < 40), 20'h1);
    endtask
    always @(negedge core_clk) begin
        if (reg_wr === 1'b1 || reg_rd === 1'b1)
            chk(got, exp_q.pop_front());
        if (dma_done === 1'b1 && dma_write === 1'b0)
            chk({4'hD, dma_rdata}, exp_q.pop_front());
    end
    initial begin
        void'($urandom(73450));
        repeat (16) @(negedge core_clk);
        srst = 0;
        for (i = 0; i < 6; i++) host(i[0], 4'($urandom), 8'($urandom));
        dma_active = 1;
        host(0, 4'h9, 8'h00);
        {dma_active, dma_req} = 2'b01;
        repeat (6) @(negedge core_clk);
        chk(20'({master_write_strobe_oe, dma_done}), 20'h0);
        {bus_grant, dma_req} = 2'b10;
        for (i = 0; i < 4; i++) dma(i[1], i != 3, i[0] ^ i[1]);
        dma(0, 0, 1);
        finish_test(0);
    end
    initial #30000 finish_test(1);
endmodule // nic_host_bus_interface_tb
`default_nettype wire
